// file: hdl/cic_defs.vh
// register offsets, field positions, reset values and vectors for the
// core interrupt control bank; included by cic_bank, its checker and the bench
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH

`define CIC_OFF_MAIN 12'h000
`define CIC_OFF_EDGE 12'h004
`define CIC_OFF_EXT 12'h008
`define CIC_OFF_CTRL 12'h00C
`define CIC_OFF_STAT 12'h010

// main control register fields
`define CIC_M_GIE 7
`define CIC_M_PEIE 6
`define CIC_M_T0E 5
`define CIC_M_I0E 4
`define CIC_M_PCE 3
`define CIC_M_T0F 2
`define CIC_M_I0F 1
`define CIC_M_PCF 0

// edge and priority register fields
`define CIC_E_PUD 7
`define CIC_E_EDG0 6
`define CIC_E_T0P 2
`define CIC_E_I3P 1
`define CIC_E_PCP 0

// external pins register fields
`define CIC_X_I2P 7
`define CIC_X_I1P 6
`define CIC_X_IE1 3
`define CIC_X_IF1 0

// own control register: bit 0 priority scheme enable
`define CIC_C_PSE 0

`define CIC_RST_MAIN 8'h00
`define CIC_RST_EDGE 8'hFF
`define CIC_RST_EXT 8'hC0
`define CIC_RST_CTRL 8'h00

`define CIC_VEC_HIGH 24'h000008
`define CIC_VEC_LOW 24'h000018

`endif

// file: hdl/cic_edge_det.v
// edge detector for one external interrupt pin
// assumes the pin is already synchronous to clk_i
`timescale 1ns/1ps
module cic_edge_det (
   input wire clk_i,
   input wire rst_n_i,
   input wire pin_i,
   input wire rising_i,
   output wire event_o
);
   reg last_q;
   reg seen_q;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         last_q <= pin_i;
         seen_q <= 1'b1;
      end
   end

   // rising when select is one, falling when zero
   assign event_o = seen_q & (rising_i ? (pin_i & ~last_q) :
                                         (~pin_i & last_q)); // RQ13
endmodule

// file: hdl/cic_port_change.v
// mismatch detector on the upper four port-b pins
// assumes port_read_i pulses when software reads the port-b register
`timescale 1ns/1ps
module cic_port_change (
   input wire clk_i,
   input wire rst_n_i,
   input wire [3:0] pins_i,
   input wire port_read_i,
   output wire mismatch_o
);
   reg [3:0] latch_q;
   reg init_q;

   // reading the port reloads the latch and ends the mismatch
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_q <= 4'h0;
         init_q <= 1'b0;
      end else begin
         init_q <= 1'b1;
         if (port_read_i || !init_q) begin
            latch_q <= pins_i; // RQ11
         end
      end
   end

   assign mismatch_o = init_q & (latch_q != pins_i); // RQ10
endmodule

// file: hdl/cic_bank.v
// core interrupt control bank: four control registers and a status word behind apb,
// flag capture, gating by enables and priority, vector to the core
// assumes request inputs are synchronous pulses or levels on clk_i and
// the core pulses core_ack_i when it takes the offered vector
//
// Contract
// (RQ1) flags set on their event whatever the enable or global bits
// (RQ2) software clears a flag before enabling it and after servicing
// (RQ3) all three registers read and write; flags clear only by software
// (RQ4) without priority, bit 7 enables all unmasked interrupts
// (RQ5) with priority, bit 7 enables high-priority interrupts
// (RQ6) without priority, bit 6 gates all peripheral interrupts
// (RQ7) with priority, bit 6 enables low-priority interrupts
// (RQ8) timer-0 overflow sets bit 2; bit 5 enables it
// (RQ9) active edge on pin 0 sets bit 1; bit 4 enables it
// (RQ10) change on upper port-b pins sets bit 0; bit 3 enables it
// (RQ11) mismatch keeps re-setting port flag until port is read
// (RQ12) bit 7 of second register disables all port-b pull-ups
// (RQ13) bits 6..3 pick rising or falling edge for pins 0..3
// (RQ14) bits 2..0 set priority of timer-0, pin 3, port change
// (RQ15) third register bits 7,6 set priority of pins 2 and 1
// (RQ16) third register bits 5..3 enable pins 3, 2 and 1
// (RQ17) third register bits 2..0 flag events on pins 3, 2 and 1
// (RQ18) priority enable bit switches the meaning of the global bits
// (RQ19) high goes to 000008h, low to 000018h; high preempts low
// (RQ20) without priority, all go to the high vector
// (RQ21) accepting clears the global bit that admitted the interrupt
// (RQ22) request only when flag, enable and global enable all set
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "cic_defs.vh"
module cic_bank (
   input wire clk_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire pready_o,
   output reg [31:0] prdata_o,
   output wire pslverr_o,
   input wire timer0_overflow_i,
   input wire [3:0] ext_pin_i,
   input wire [3:0] upper_port_pins_i,
   input wire port_b_read_i,
   input wire periph_high_req_i,
   input wire periph_low_req_i,
   input wire core_ack_i,
   output wire pullup_disable_o,
   output reg irq_valid_o,
   output reg [23:0] irq_vector_o,
   output reg irq_high_o
);
   reg [7:0] main_q;
   reg [7:0] edge_q;
   reg [7:0] ext_q;
   reg [7:0] ctrl_q;
   reg [7:0] main_d;
   reg [7:0] ext_d;
   reg [7:0] ctrl_d;
   reg [1:0] serv_q;
   wire [3:0] pin_evt;
   wire mismatch;
   wire wr_en;
   wire rd_en;
   wire addr_ok;
   wire pse;
   reg [31:0] rdata;

   localparam ST_IDLE = 3'b001;
   localparam ST_HIGH = 3'b010;
   localparam ST_LOW = 3'b100;
   reg [2:0] st_q;

   // flag and its write: software write lands, but a set wins
   function flag_next;
      input cur;
      input wr;
      input wbit;
      input evt;
      begin
         flag_next = evt | (wr ? wbit : cur);
      end
   endfunction

   // request of one source: flag, enable and priority routed
   function src_req;
      input flag;
      input en;
      input prio;
      input want_high;
      begin
         src_req = flag & en & (prio == want_high);
      end
   endfunction

   // write strobe of one register: access phase of a write to its offset
   function wr_hit;
      input en;
      input [11:0] addr;
      input [11:0] off;
      begin
         wr_hit = en & (addr == off);
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pin
         cic_edge_det u_edge (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(ext_pin_i[g]),
            .rising_i(edge_q[`CIC_E_EDG0 - g]),
            .event_o(pin_evt[g])
         );
      end
   endgenerate

   cic_port_change u_pc (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pins_i(upper_port_pins_i),
      .port_read_i(port_b_read_i),
      .mismatch_o(mismatch)
   );

   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   wire wr_main = wr_hit(wr_en, paddr_i, `CIC_OFF_MAIN);
   wire wr_edge = wr_hit(wr_en, paddr_i, `CIC_OFF_EDGE);
   wire wr_ext = wr_hit(wr_en, paddr_i, `CIC_OFF_EXT);
   wire wr_ctrl = wr_hit(wr_en, paddr_i, `CIC_OFF_CTRL);
   assign addr_ok = (paddr_i == `CIC_OFF_MAIN) |
                    (paddr_i == `CIC_OFF_EDGE) |
                    (paddr_i == `CIC_OFF_EXT) |
                    (paddr_i == `CIC_OFF_CTRL) |
                    (paddr_i == `CIC_OFF_STAT);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign pse = ctrl_q[`CIC_C_PSE];
   assign pullup_disable_o = edge_q[`CIC_E_PUD]; // RQ12

   // gated requests per source, regardless of level
   wire t0_any = main_q[`CIC_M_T0F] & main_q[`CIC_M_T0E];
   wire i0_any = main_q[`CIC_M_I0F] & main_q[`CIC_M_I0E];
   wire pc_any = main_q[`CIC_M_PCF] & main_q[`CIC_M_PCE];
   wire [2:0] xf = ext_q[`CIC_X_IF1 +: 3];
   wire [2:0] xe = ext_q[`CIC_X_IE1 +: 3];
   wire [2:0] xp = {edge_q[`CIC_E_I3P], ext_q[`CIC_X_I2P],
                    ext_q[`CIC_X_I1P]};
   wire core_any = t0_any | i0_any | pc_any | (|(xf & xe));

   // pin 0 always high priority; others by their bit
   wire hi_src = src_req(main_q[`CIC_M_T0F], main_q[`CIC_M_T0E],
                         edge_q[`CIC_E_T0P], 1'b1) | i0_any |
                 src_req(main_q[`CIC_M_PCF], main_q[`CIC_M_PCE],
                         edge_q[`CIC_E_PCP], 1'b1) |
                 src_req(xf[0], xe[0], xp[0], 1'b1) |
                 src_req(xf[1], xe[1], xp[1], 1'b1) |
                 src_req(xf[2], xe[2], xp[2], 1'b1) |
                 periph_high_req_i; // RQ14 RQ15 RQ22
   wire lo_src = src_req(main_q[`CIC_M_T0F], main_q[`CIC_M_T0E],
                         edge_q[`CIC_E_T0P], 1'b0) |
                 src_req(main_q[`CIC_M_PCF], main_q[`CIC_M_PCE],
                         edge_q[`CIC_E_PCP], 1'b0) |
                 src_req(xf[0], xe[0], xp[0], 1'b0) |
                 src_req(xf[1], xe[1], xp[1], 1'b0) |
                 src_req(xf[2], xe[2], xp[2], 1'b0) |
                 periph_low_req_i; // RQ22

   wire gie = main_q[`CIC_M_GIE];
   wire peie = main_q[`CIC_M_PEIE];
   // compatibility: gie over all, peie over peripheral sources
   wire compat_req = gie & (core_any |
                     (peie & (periph_high_req_i | periph_low_req_i)));
                     // RQ4 RQ6 RQ20
   wire hi_req = pse ? (gie & hi_src) : compat_req; // RQ5 RQ18
   // low level needs both bits since a cleared bit 7 blocks everything
   wire lo_req = pse & gie & peie & lo_src; // RQ7
   wire take_hi = (st_q != ST_HIGH) & hi_req; // RQ19
   wire take_lo = (st_q == ST_IDLE) & ~hi_req & lo_req;
   wire accept = irq_valid_o & core_ack_i;

   always @* begin
      main_d = main_q;
      ext_d = ext_q;
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = {7'h00, pwdata_i[`CIC_C_PSE]};
      end
      main_d[`CIC_M_T0F] = flag_next(main_q[`CIC_M_T0F], wr_main,
         pwdata_i[`CIC_M_T0F], timer0_overflow_i); // RQ1 RQ8
      main_d[`CIC_M_I0F] = flag_next(main_q[`CIC_M_I0F], wr_main,
         pwdata_i[`CIC_M_I0F], pin_evt[0]); // RQ9
      main_d[`CIC_M_PCF] = flag_next(main_q[`CIC_M_PCF], wr_main,
         pwdata_i[`CIC_M_PCF], mismatch); // RQ10 RQ11
      if (wr_main) begin
         main_d[7:3] = pwdata_i[7:3]; // RQ3
      end
      if (wr_ext) begin
         ext_d[7:3] = pwdata_i[7:3]; // RQ16
      end
      ext_d[2] = flag_next(ext_q[2], wr_ext, pwdata_i[2], pin_evt[3]);
      ext_d[1] = flag_next(ext_q[1], wr_ext, pwdata_i[1], pin_evt[2]);
      ext_d[0] = flag_next(ext_q[0], wr_ext, pwdata_i[0],
         pin_evt[1]); // RQ17
      // acceptance clears the admitting global bit, after any write
      if (accept) begin
         if (pse && !irq_high_o) begin
            main_d[`CIC_M_PEIE] = 1'b0; // RQ21
         end else begin
            main_d[`CIC_M_GIE] = 1'b0; // RQ21
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_q <= `CIC_RST_MAIN;
         edge_q <= `CIC_RST_EDGE;
         ext_q <= `CIC_RST_EXT;
         ctrl_q <= `CIC_RST_CTRL;
      end else begin
         main_q <= main_d;
         ext_q <= ext_d;
         ctrl_q <= ctrl_d;
         if (wr_edge) begin
            edge_q <= pwdata_i[7:0]; // RQ3
         end
      end
   end

   // offer and service tracking; serv_q: bit1 high, bit0 low in service
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_IDLE;
         serv_q <= 2'b00;
         irq_valid_o <= 1'b0;
         irq_vector_o <= 24'h000000;
         irq_high_o <= 1'b0;
      end else begin
         if (accept) begin
            irq_valid_o <= 1'b0;
            st_q <= irq_high_o ? ST_HIGH : ST_LOW;
            serv_q <= irq_high_o ? (serv_q | 2'b10) : 2'b01; // RQ19
         end else if (take_hi && !(irq_valid_o && irq_high_o)) begin
            irq_valid_o <= 1'b1;
            irq_high_o <= 1'b1;
            irq_vector_o <= `CIC_VEC_HIGH; // RQ19 RQ20
         end else if (take_lo && !irq_valid_o) begin
            irq_valid_o <= 1'b1;
            irq_high_o <= 1'b0;
            irq_vector_o <= `CIC_VEC_LOW; // RQ19
         end else if (irq_valid_o && !(irq_high_o ? hi_req : lo_req))
         begin
            irq_valid_o <= 1'b0;
         end
         // return re-arms: the level ends when its global bit is set again
         case (st_q)
            ST_IDLE: begin
            end
            ST_HIGH: begin
               if (!accept && gie) begin
                  // a preempted low service resumes
                  if (serv_q[0]) begin
                     st_q <= ST_LOW;
                     serv_q <= 2'b01;
                  end else begin
                     st_q <= ST_IDLE;
                     serv_q <= 2'b00;
                  end
               end
            end
            ST_LOW: begin
               if (!accept && peie) begin
                  st_q <= ST_IDLE;
                  serv_q <= 2'b00;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   always @* begin
      rdata = 32'h00000000;
      case (paddr_i)
         `CIC_OFF_MAIN: rdata = {24'h000000, main_q};
         `CIC_OFF_EDGE: rdata = {24'h000000, edge_q};
         `CIC_OFF_EXT: rdata = {24'h000000, ext_q};
         `CIC_OFF_CTRL: rdata = {24'h000000, ctrl_q};
         `CIC_OFF_STAT: begin
            rdata = {28'h0000000, st_q[2:1] != 2'b00, serv_q,
                     irq_valid_o};
         end
         default: rdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h00000000;
      end else if (rd_en) begin
         prdata_o <= rdata;
      end
   end
endmodule

// file: dv/cic_bank_checker.sv
// port assertions for the core interrupt control bank
// assumes the apb slave and vector handshake ports of cic_bank
`timescale 1ns/1ps
`include "cic_defs.vh"
module cic_bank_checker (
   input wire clk_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pslverr_o,
   input wire core_ack_i,
   input wire pullup_disable_o,
   input wire irq_valid_o,
   input wire [23:0] irq_vector_o,
   input wire irq_high_o
);
   wire acc = psel_i && penable_i;
   wire setup_rd = psel_i && !penable_i && !pwrite_i;
   wire mapped = paddr_i[11:5] == 7'h00 && paddr_i[1:0] == 2'h0 &&
      paddr_i[4:2] <= 3'h4;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   unmapped_err_a: assert property (acc && !mapped |-> pslverr_o)
      else $error("no error on unmapped access");
   unmapped_rd_a: assert property (setup_rd && !mapped |=>
      prdata_o == 0) else $error("unmapped read not zero");
   upper_zero_a: assert property (prdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   pullup_wr_a: assert property (acc && pwrite_i &&
      paddr_i == `CIC_OFF_EDGE |=> pullup_disable_o == $past(pwdata_i[7]))
      else $error("pull-up disable not written");
   pullup_rd_a: assert property (setup_rd &&
      paddr_i == `CIC_OFF_EDGE |=> prdata_o[7] == pullup_disable_o)
      else $error("pull-up disable differs from register");
   vec_high_a: assert property (irq_valid_o && irq_high_o |->
      irq_vector_o == `CIC_VEC_HIGH) else $error("bad high vector");
   vec_low_a: assert property (irq_valid_o && !irq_high_o |->
      irq_vector_o == `CIC_VEC_LOW) else $error("bad low vector");
   high_ack_a: assert property (irq_valid_o && irq_high_o &&
      core_ack_i |=> !irq_valid_o [*2]) else $error("offer after accept");
   gie_off_a: assert property (acc && pwrite_i &&
      paddr_i == `CIC_OFF_MAIN && !pwdata_i[7] |=> ##1 !irq_valid_o)
      else $error("offer with global enable clear");
   cover property (irq_valid_o && !irq_high_o && core_ack_i);
   cover property (irq_valid_o && irq_high_o && core_ack_i);
   cover property (acc && !mapped);
endmodule
bind cic_bank cic_bank_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pslverr_o(pslverr_o), .core_ack_i(core_ack_i),
   .pullup_disable_o(pullup_disable_o), .irq_valid_o(irq_valid_o),
   .irq_vector_o(irq_vector_o), .irq_high_o(irq_high_o));

// file: dv/cic_core_model.sv
// core sequencer model: takes an offered vector after wait_i cycles
// assumes irq_valid_i stands until acknowledged
`timescale 1ns/1ps
module cic_core_model (
   input wire clk_i,
   input wire rst_n_i,
   input wire irq_valid_i,
   input wire [1:0] wait_i,
   output reg ack_o
);
   reg [1:0] cnt_q;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         cnt_q <= 2'h0;
      end else if (irq_valid_i && !ack_o && cnt_q == wait_i) begin
         ack_o <= 1'b1;
      end else begin
         ack_o <= 1'b0;
         cnt_q <= (irq_valid_i && !ack_o) ? cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the core interrupt control bank
// assumes the checker and core model files are compiled before it
`timescale 1ns/1ps
`include "cic_defs.vh"
module tb_top;
   reg clk_i, rst_n_i, psel, pen, pwr, t0, pbrd, phr, plr, rerr;
   reg [11:0] pa;
   reg [31:0] pwd, rdv, seed;
   reg [3:0] pins, upins;
   reg [1:0] wt;
   wire prdy, perr, pud, ack, valid, high;
   wire [31:0] prd;
   wire [23:0] vec;
   integer fail_count, n_compared, cyc, i, pol;
   cic_bank dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
      .timer0_overflow_i(t0), .ext_pin_i(pins), .upper_port_pins_i(upins),
      .port_b_read_i(pbrd), .periph_high_req_i(phr),
      .periph_low_req_i(plr), .core_ack_i(ack), .pullup_disable_o(pud),
      .irq_valid_o(valid), .irq_vector_o(vec), .irq_high_o(high));
   cic_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .irq_valid_i(valid), .wait_i(wt), .ack_o(ack));
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   task tally_and_finish;
      begin
         $display("compared %0d failed %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         psel <= 1'b1;
         pwr <= w;
         pa <= a;
         pwd <= d;
         @(posedge clk_i);
         pen <= 1'b1;
         @(posedge clk_i);
         while (prdy !== 1'b1)
            @(posedge clk_i);
         rdv = prd;
         rerr = perr;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [7:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(rdv, {24'h0, e});
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task irq(input [23:0] v, input h);
      begin
         seed = xs(seed);
         wt <= seed[1:0];
         for (i = 0; i < 40 && valid !== 1'b1; i = i + 1)
            @(posedge clk_i);
         chk({valid, high, vec}, {1'b1, h, v});
         for (i = 0; i < 40 && valid === 1'b1; i = i + 1)
            @(posedge clk_i);
      end
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         tally_and_finish;
      end
   end
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      {psel, pen, pwr, t0, pbrd, phr, plr} = 7'h00;
      pa = 12'h000;
      pwd = 32'h0;
      {pins, upins, wt} = 10'h000;
      {fail_count, n_compared, cyc} = 0;
      seed = 32'hB0D6C924;
      rst_n_i = 1'b0;
      tick(6);
      rst_n_i <= 1'b1;
      rd(`CIC_OFF_MAIN, 8'h00);
      chk(rerr, 0);
      rd(`CIC_OFF_EDGE, 8'hFF);
      rd(`CIC_OFF_EXT, 8'hC0);
      chk(pud, 1);
      repeat (4) begin
         seed = xs(seed);
         apb(1'b1, `CIC_OFF_EDGE, seed);
         rd(`CIC_OFF_EDGE, seed[7:0]);
         chk(pud, seed[7]);
         apb(1'b1, `CIC_OFF_EXT, seed >> 8);
         rd(`CIC_OFF_EXT, seed[15:8]);
         apb(1'b1, `CIC_OFF_MAIN, seed[23:16] & 8'h7F);
         rd(`CIC_OFF_MAIN, seed[23:16] & 8'h7F);
      end
      apb(1'b1, 12'h014, 32'hFF);
      chk(rerr, 1);
      rd(12'h014, 8'h00);
      chk(rerr, 1);
      apb(1'b1, `CIC_OFF_MAIN, 32'h0);
      @(posedge clk_i);
      t0 <= 1'b1;
      @(posedge clk_i);
      t0 <= 1'b0;
      rd(`CIC_OFF_MAIN, 8'h04);
      apb(1'b1, `CIC_OFF_MAIN, 32'h0);
      rd(`CIC_OFF_MAIN, 8'h00);
      for (pol = 1; pol >= 0; pol = pol - 1) begin
         apb(1'b1, `CIC_OFF_EDGE, {25'h1, {4{pol[0]}}, 3'h7});
         apb(1'b1, `CIC_OFF_MAIN, 32'h0);
         apb(1'b1, `CIC_OFF_EXT, 32'hC0);
         for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_i);
            pins[i] <= pol[0];
         end
         tick(3);
         rd(`CIC_OFF_MAIN, 8'h02);
         rd(`CIC_OFF_EXT, 8'hC7);
      end
      seed = xs(seed);
      upins <= seed[3:0] | 4'h1;
      tick(2);
      apb(1'b1, `CIC_OFF_MAIN, 32'h0);
      rd(`CIC_OFF_MAIN, 8'h01);
      @(posedge clk_i);
      pbrd <= 1'b1;
      @(posedge clk_i);
      pbrd <= 1'b0;
      apb(1'b1, `CIC_OFF_MAIN, 32'h0);
      rd(`CIC_OFF_MAIN, 8'h00);
      apb(1'b1, `CIC_OFF_EDGE, 32'h80);
      apb(1'b1, `CIC_OFF_MAIN, 32'h20);
      @(posedge clk_i);
      t0 <= 1'b1;
      @(posedge clk_i);
      t0 <= 1'b0;
      tick(4);
      chk(valid, 0);
      apb(1'b1, `CIC_OFF_MAIN, 32'hA4);
      irq(`CIC_VEC_HIGH, 1'b1);
      rd(`CIC_OFF_MAIN, 8'h24);
      apb(1'b1, `CIC_OFF_MAIN, 32'h80);
      phr <= 1'b1;
      tick(4);
      chk(valid, 0);
      apb(1'b1, `CIC_OFF_MAIN, 32'hC0);
      irq(`CIC_VEC_HIGH, 1'b1);
      phr <= 1'b0;
      rd(`CIC_OFF_MAIN, 8'h40);
      apb(1'b1, `CIC_OFF_CTRL, 32'h1);
      apb(1'b1, `CIC_OFF_MAIN, 32'hE4);
      irq(`CIC_VEC_LOW, 1'b0);
      rd(`CIC_OFF_MAIN, 8'hA4);
      @(posedge clk_i);
      phr <= 1'b1;
      irq(`CIC_VEC_HIGH, 1'b1);
      phr <= 1'b0;
      rd(`CIC_OFF_MAIN, 8'h24);
      tick(5);
      tally_and_finish;
   end
endmodule
